// ---- logic/sub_fill_sleep_exec.sv ----
// Executor for fill-ones, sleep and the four subtractions, with an AXI4-Lite slave
`default_nettype none

// How it works
// - Opcode 0110 100a with a file address writes all ones there and keeps every flag.
// - With access bit zero and extended set on, file offsets up to 0x5F add to the index base.
// - Access bit zero picks the access bank, one picks the bank select pointer's bank.
// - For subtractions with a destination bit, zero writes the accumulator, one the file.
// - Opcode 0x0003 puts the core to sleep with its clock considered stopped.
// - Sleep clears watchdog and postscaler, sets timeout status and clears powerdown status.
// - Prefix 0101 01da computes accumulator minus file minus inverted carry.
// - Every subtraction updates negative, overflow, carry, nibble carry and zero.
// - Prefix 0000 1000 puts literal minus accumulator into the accumulator.
// - Prefix 0101 11da computes file minus accumulator to the chosen destination.
// - Prefix 0101 10da computes file minus accumulator minus inverted carry.
module sub_fill_sleep_exec #(
  parameter int unsigned MEM_WORDS  = sub_exec_pkg::MEM_WORDS_DEFAULT,
  parameter int unsigned PRESCALE   = sub_exec_pkg::WATCH_PRESCALE,
  parameter int unsigned POSTSCALE  = sub_exec_pkg::WATCH_POSTSCALE
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address channel
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Core state
  output logic             core_asleep
);

  localparam int unsigned IDX_W  = $clog2(MEM_WORDS);
  localparam int unsigned PRE_W  = $clog2(PRESCALE);
  localparam int unsigned POST_W = $clog2(POSTSCALE);

  // ****************************************
  // State
  // ****************************************
  sub_exec_pkg::mode_t    mode;
  sub_exec_pkg::flags_t   flags;
  sub_exec_pkg::alu_out_t alu;
  logic [7:0]             mem [MEM_WORDS];
  logic [15:0]            opcode;
  logic [7:0]             acc;
  logic [3:0]             bank_select_pointer;
  logic [11:0]            index_base;
  logic [11:0]            mem_addr;
  logic                   ext_en;
  logic                   watch_en;
  logic                   timeout_status_bit;
  logic                   powerdown_status_bit;
  logic                   bad_op;
  logic [PRE_W-1:0]       pre_cnt;
  logic [POST_W-1:0]      post_cnt;
  logic                   watch_tick;
  logic                   watch_timeout;

  // ****************************************
  // Bus strobes
  // ****************************************
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_hit;
  logic [15:0] wr_mask;
  logic        wake_req;
  logic [31:0] next_rdata;
  logic        rd_hit;
  logic [15:0] index_merge;
  logic [15:0] addr_merge;

  // A write is taken only with both address and data present
  assign wr_fire  = awready && awvalid && wready && wvalid;
  assign rd_fire  = arready && arvalid;
  assign wr_mask  = {{8{wstrb[1]}}, {8{wstrb[0]}}};
  assign wake_req = wr_fire && (awaddr == sub_exec_pkg::OFS_CTRL)
                    && wstrb[0] && wdata[sub_exec_pkg::CT_WAKE];

  // Merge a 16-bit register with the byte lanes being written
  function automatic logic [15:0] merge16(input logic [15:0] old_v);
    merge16 = (old_v & ~wr_mask) | (wdata[15:0] & wr_mask);
  endfunction

  // Twelve-bit pointers keep only the low bits of the merged word
  assign index_merge = merge16({4'h0, index_base});
  assign addr_merge  = merge16({4'h0, mem_addr});

  // ****************************************
  // Decode
  // ****************************************
  logic [11:0]      file_addr;
  logic [IDX_W-1:0] file_idx;
  logic [IDX_W-1:0] win_idx;
  logic [7:0]       file_val;
  logic             exec;
  logic             is_fill;
  logic             is_sfab;
  logic             is_safb;
  logic             is_saf;
  logic             is_sal;
  logic             is_sleep;
  logic             is_sub;
  logic             dest_file;
  logic [7:0]       op_min;
  logic [7:0]       op_sub;
  logic             op_cin;

  file_addr_gen u_addr (
    .file_ofs            (opcode[7:0]),
    .access_bit          (opcode[sub_exec_pkg::OP_ACCESS]),
    .ext_en              (ext_en),
    .bank_select_pointer (bank_select_pointer),
    .index_base          (index_base),
    .file_addr           (file_addr)
  );

  // Memory is smaller than the full space, so addresses wrap onto it
  assign file_idx = file_addr[IDX_W-1:0];
  assign win_idx  = mem_addr[IDX_W-1:0];
  assign file_val = mem[file_idx];
  assign exec     = (mode == sub_exec_pkg::MODE_EXEC);

  // Opcode pattern match
  assign is_fill  = (opcode[15:9] == sub_exec_pkg::OPC_FILL_ONES);
  assign is_sfab  = (opcode[15:10] == sub_exec_pkg::OPC_SUB_FILE_ACC_B);
  assign is_safb  = (opcode[15:10] == sub_exec_pkg::OPC_SUB_ACC_FILE_B);
  assign is_saf   = (opcode[15:10] == sub_exec_pkg::OPC_SUB_ACC_FILE);
  assign is_sal   = (opcode[15:8] == sub_exec_pkg::OPC_SUB_ACC_LIT);
  assign is_sleep = (opcode == sub_exec_pkg::OPC_SLEEP);
  assign is_sub   = is_sfab || is_safb || is_saf || is_sal;
  assign dest_file = opcode[sub_exec_pkg::OP_DEST] && !is_sal;

  // Operand steering; plain subtractions feed a carry of one (no borrow)
  always_comb begin
    op_min = file_val;
    op_sub = acc;
    op_cin = 1'b1;
    if (is_sfab) begin
      op_min = acc;
      op_sub = file_val;
      op_cin = flags.c;
    end else if (is_safb) begin
      op_cin = flags.c;
    end else if (is_sal) begin
      op_min = opcode[7:0];
    end
  end

  sub_alu u_alu (
    .minuend    (op_min),
    .subtrahend (op_sub),
    .carry_in   (op_cin),
    .result     (alu)
  );

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************

  // Ready pulses for one cycle once both write channels are offered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready  <= awvalid && wvalid && !awready && !bvalid;
    end
  end

  // Write response, held until accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= sub_exec_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? sub_exec_pkg::RESP_OKAY : sub_exec_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read address accept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
    end else begin
      arready <= arvalid && !arready && !rvalid;
    end
  end

  // Decode of mapped offsets
  always_comb begin
    wr_hit = 1'b1;
    case (awaddr)
      sub_exec_pkg::OFS_OPCODE, sub_exec_pkg::OFS_ACC,
      sub_exec_pkg::OFS_STATUS, sub_exec_pkg::OFS_BANK,
      sub_exec_pkg::OFS_CTRL, sub_exec_pkg::OFS_INDEX,
      sub_exec_pkg::OFS_MEM_ADDR, sub_exec_pkg::OFS_MEM_DATA: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux; unused bits read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    case (araddr)
      sub_exec_pkg::OFS_OPCODE:   next_rdata[15:0] = opcode;
      sub_exec_pkg::OFS_ACC:      next_rdata[7:0]  = acc;
      sub_exec_pkg::OFS_STATUS: begin
        next_rdata[sub_exec_pkg::ST_FLAGS_W-1:0] = flags;
        next_rdata[sub_exec_pkg::ST_POWERDOWN]   = powerdown_status_bit;
        next_rdata[sub_exec_pkg::ST_TIMEOUT]     = timeout_status_bit;
        next_rdata[sub_exec_pkg::ST_ASLEEP]      = core_asleep;
        next_rdata[sub_exec_pkg::ST_BAD_OP]      = bad_op;
      end
      sub_exec_pkg::OFS_BANK:     next_rdata[3:0]  = bank_select_pointer;
      sub_exec_pkg::OFS_CTRL: begin
        next_rdata[sub_exec_pkg::CT_EXT_EN]   = ext_en;
        next_rdata[sub_exec_pkg::CT_WATCH_EN] = watch_en;
      end
      sub_exec_pkg::OFS_INDEX:    next_rdata[11:0] = index_base;
      sub_exec_pkg::OFS_MEM_ADDR: next_rdata[11:0] = mem_addr;
      sub_exec_pkg::OFS_MEM_DATA: next_rdata[7:0]  = mem[win_idx];
      default:                    rd_hit = 1'b0;
    endcase
  end

  // Read data, held until accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= sub_exec_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= rd_hit ? sub_exec_pkg::RESP_OKAY : sub_exec_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_select_pointer <= 4'h0;
      ext_en              <= 1'b0;
      watch_en            <= 1'b0;
      index_base          <= sub_exec_pkg::INDEX_RESET;
      mem_addr            <= 12'h000;
    end else if (wr_fire) begin
      if (awaddr == sub_exec_pkg::OFS_BANK && wstrb[0]) begin
        bank_select_pointer <= wdata[3:0];
      end
      if (awaddr == sub_exec_pkg::OFS_CTRL && wstrb[0]) begin
        ext_en   <= wdata[sub_exec_pkg::CT_EXT_EN];
        watch_en <= wdata[sub_exec_pkg::CT_WATCH_EN];
      end
      if (awaddr == sub_exec_pkg::OFS_INDEX) begin
        index_base <= index_merge[11:0];
      end
      if (awaddr == sub_exec_pkg::OFS_MEM_ADDR) begin
        mem_addr <= addr_merge[11:0];
      end
    end
  end

  // ****************************************
  // Core sequencing
  // ****************************************

  // Writes to the opcode register start one execution; sleeping ignores them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode        <= sub_exec_pkg::MODE_RUN;
      opcode      <= sub_exec_pkg::OPCODE_RESET;
      core_asleep <= 1'b0;
    end else begin
      case (mode)
        sub_exec_pkg::MODE_RUN: begin
          if (wr_fire && awaddr == sub_exec_pkg::OFS_OPCODE) begin
            opcode <= merge16(opcode);
            mode   <= sub_exec_pkg::MODE_EXEC;
          end
        end
        sub_exec_pkg::MODE_EXEC: begin
          if (is_sleep) begin
            mode        <= sub_exec_pkg::MODE_SLEEP;
            core_asleep <= 1'b1;
          end else begin
            mode <= sub_exec_pkg::MODE_RUN;
          end
        end
        sub_exec_pkg::MODE_SLEEP: begin
          if (wake_req || watch_timeout) begin
            mode        <= sub_exec_pkg::MODE_RUN;
            core_asleep <= 1'b0;
          end
        end
        default: begin
          mode        <= sub_exec_pkg::MODE_RUN;
          core_asleep <= 1'b0;
        end
      endcase
    end
  end

  // Accumulator: results with destination zero, or a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= sub_exec_pkg::ACC_RESET;
    end else if (exec && is_sub && !dest_file) begin
      acc <= alu.value;
    end else if (wr_fire && awaddr == sub_exec_pkg::OFS_ACC && wstrb[0]) begin
      acc <= wdata[7:0];
    end
  end

  // Data memory: fill, file-destined results, or the software window
  always_ff @(posedge aclk) begin
    if (exec && is_fill) begin
      mem[file_idx] <= sub_exec_pkg::FILL_VALUE;
    end else if (exec && is_sub && dest_file) begin
      mem[file_idx] <= alu.value;
    end else if (wr_fire && awaddr == sub_exec_pkg::OFS_MEM_DATA && wstrb[0]) begin
      mem[win_idx] <= wdata[7:0];
    end
  end

  // Arithmetic flags; fill and sleep leave them alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else if (exec && is_sub) begin
      flags <= alu.flags;
    end else if (wr_fire && awaddr == sub_exec_pkg::OFS_STATUS && wstrb[0]) begin
      flags <= wdata[sub_exec_pkg::ST_FLAGS_W-1:0];
    end
  end

  // Unknown opcodes are ignored but reported until the next good one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bad_op <= 1'b0;
    end else if (exec) begin
      bad_op <= !(is_sub || is_fill || is_sleep);
    end
  end

  // Power status bits are both high out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_status_bit   <= 1'b1;
      powerdown_status_bit <= 1'b1;
    end else if (exec && is_sleep) begin
      timeout_status_bit   <= 1'b1;
      powerdown_status_bit <= 1'b0;
    end else if (watch_timeout && mode == sub_exec_pkg::MODE_SLEEP) begin
      timeout_status_bit   <= 1'b0;
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  // Prescaler gives a one-cycle tick; the postscaler counts ticks to timeout
  assign watch_tick    = watch_en && (pre_cnt == PRE_W'(PRESCALE - 1));
  assign watch_timeout = watch_tick && (post_cnt == POST_W'(POSTSCALE - 1));

  // Sleep entry restarts both stages so a full period precedes a watchdog wake
  always_ff @(posedge aclk) begin
    if (!aresetn || !watch_en || (exec && is_sleep)) begin
      pre_cnt  <= '0;
      post_cnt <= '0;
    end else if (watch_tick) begin
      pre_cnt  <= '0;
      post_cnt <= watch_timeout ? '0 : post_cnt + 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- logic/sub_exec_pkg.sv ----
// Shared constants, register map and carrier types of the subtract/fill/sleep executor
`default_nettype none
package sub_exec_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFS_OPCODE   = 8'h00;
  localparam logic [7:0]  OFS_ACC      = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_BANK     = 8'h0C;
  localparam logic [7:0]  OFS_CTRL     = 8'h10;
  localparam logic [7:0]  OFS_INDEX    = 8'h14;
  localparam logic [7:0]  OFS_MEM_ADDR = 8'h18;
  localparam logic [7:0]  OFS_MEM_DATA = 8'h1C;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned ST_FLAGS_W   = 5;
  localparam int unsigned ST_POWERDOWN = 5;
  localparam int unsigned ST_TIMEOUT   = 6;
  localparam int unsigned ST_ASLEEP    = 7;
  localparam int unsigned ST_BAD_OP    = 8;
  localparam int unsigned CT_EXT_EN    = 0;
  localparam int unsigned CT_WATCH_EN  = 1;
  localparam int unsigned CT_WAKE      = 2;
  localparam int unsigned OP_ACCESS    = 8;
  localparam int unsigned OP_DEST      = 9;

  // ****************************************
  // Opcodes and addressing constants
  // ****************************************
  localparam logic [6:0]  OPC_FILL_ONES      = 7'h34;
  localparam logic [5:0]  OPC_SUB_FILE_ACC_B = 6'h15;
  localparam logic [5:0]  OPC_SUB_ACC_FILE_B = 6'h16;
  localparam logic [5:0]  OPC_SUB_ACC_FILE   = 6'h17;
  localparam logic [7:0]  OPC_SUB_ACC_LIT    = 8'h08;
  localparam logic [15:0] OPC_SLEEP          = 16'h0003;
  localparam logic [7:0]  FILL_VALUE         = 8'hFF;
  localparam logic [7:0]  LIT_OFS_LIMIT      = 8'h5F;
  localparam logic [3:0]  LOW_ACCESS_BANK    = 4'h0;
  localparam logic [3:0]  HIGH_ACCESS_BANK   = 4'hF;

  // ****************************************
  // Reset values and watchdog defaults
  // ****************************************
  localparam logic [7:0]  ACC_RESET          = 8'h00;
  localparam logic [15:0] OPCODE_RESET       = 16'h0000;
  localparam logic [11:0] INDEX_RESET        = 12'h000;
  localparam int unsigned WATCH_PRESCALE     = 128;
  localparam int unsigned WATCH_POSTSCALE    = 64;
  localparam int unsigned MEM_WORDS_DEFAULT  = 256;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_EXEC  = 2'b01,
    MODE_SLEEP = 2'b11
  } mode_t;

  typedef struct packed {
    logic n;
    logic arith_sign_error;
    logic z;
    logic nibble_carry;
    logic c;
  } flags_t;

  typedef struct packed {
    logic [7:0] value;
    flags_t     flags;
  } alu_out_t;

endpackage
`default_nettype wire

// ---- logic/sub_alu.sv ----
// Eight-bit subtractor with the full arithmetic flag set
`default_nettype none
module sub_alu (
  // Operands
  input  wire logic [7:0]            minuend,
  input  wire logic [7:0]            subtrahend,
  input  wire logic                  carry_in,
  // Result
  output var  sub_exec_pkg::alu_out_t result
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Two's complement: add the inverted subtrahend; carry_in low is a borrow
  always_comb begin
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    result.value                  = full_sum[7:0];
    result.flags.c                = full_sum[8];
    result.flags.nibble_carry     = low_sum[4];
    result.flags.z                = (full_sum[7:0] == 8'h00);
    result.flags.n                = full_sum[7];
    // Overflow when operand signs differ and the result sign leaves the minuend's
    result.flags.arith_sign_error = (minuend[7] != subtrahend[7])
                                    && (full_sum[7] != minuend[7]);
  end

endmodule
`default_nettype wire

// ---- logic/file_addr_gen.sv ----
// Data memory address generation for byte-oriented instructions
`default_nettype none
module file_addr_gen (
  // Instruction fields
  input  wire logic [7:0]  file_ofs,
  input  wire logic        access_bit,
  // Addressing state
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank_select_pointer,
  input  wire logic [11:0] index_base,
  // Result
  output logic      [11:0] file_addr
);

  // Access bank low or high half, indexed window, or banked address
  always_comb begin
    if (access_bit) begin
      file_addr = {bank_select_pointer, file_ofs};
    end else if (file_ofs <= sub_exec_pkg::LIT_OFS_LIMIT) begin
      if (ext_en) begin
        file_addr = index_base + {4'h0, file_ofs};
      end else begin
        file_addr = {sub_exec_pkg::LOW_ACCESS_BANK, file_ofs};
      end
    end else begin
      file_addr = {sub_exec_pkg::HIGH_ACCESS_BANK, file_ofs};
    end
  end

endmodule
`default_nettype wire

// ---- dv/sub_fill_sleep_exec_assertions.sv ----
// Checker of the executor's bus handshakes and sleep entry
`default_nettype none
module sub_fill_sleep_exec_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  // Read channels
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Core state
  input wire logic        core_asleep
);
  // One domain, so clock and reset are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****
  // Properties
  // ****
  property p_pair;
    awready |-> wready;
  endproperty
  a_pair: assert property (p_pair) else $error("Address and data ready split");
  property p_pulse;
    awready |=> !awready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Write ready longer than a cycle");
  property p_prompt;
    awvalid && wvalid && !bvalid && !awready |-> ##[1:2] awready;
  endproperty
  a_prompt: assert property (p_prompt) else $error("Write not taken in time");
  property p_bresp;
    awvalid && awready |=> bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("Write response late");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("Write response dropped early");
  property p_rresp;
    arvalid && arready |=> rvalid;
  endproperty
  a_rresp: assert property (p_rresp) else $error("Read data late");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("Read data dropped early");
  property p_unmap;
    awvalid && awready && awaddr == 8'h20 |=> bresp == sub_exec_pkg::RESP_SLVERR;
  endproperty
  a_unmap: assert property (p_unmap) else $error("Unmapped write not refused");
  property p_sleep;
    awvalid && awready && awaddr == sub_exec_pkg::OFS_OPCODE && wstrb[1:0] == 2'h3
      && wdata[15:0] == sub_exec_pkg::OPC_SLEEP |-> ##2 core_asleep;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep not entered");
endmodule

bind sub_fill_sleep_exec sub_fill_sleep_exec_assertions chk_u (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .core_asleep
);
`default_nettype wire

// ---- dv/sub_fill_sleep_exec_test.sv ----
// Self-checking bench of the subtract, fill and sleep executor
`default_nettype none
module sub_fill_sleep_exec_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Signals and vectors
  // ****
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, core_asleep;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [63:0] v;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n;
  // Watchdog span in cycles, prescale times postscale as set below
  localparam int WD = 16;
  // Opcode, acc, file, status; then acc, file, flags expected
  localparam logic [63:0] VEC [14] = '{
    64'h5740_02_03_01_02_FF_10, 64'h5540_05_02_01_03_02_03, 64'h5540_02_01_00_00_01_07,
    64'h0802_01_00_00_01_00_03, 64'h0802_02_00_00_00_00_07, 64'h0802_03_00_00_FF_00_10,
    64'h5F40_02_03_00_02_01_03, 64'h5D40_02_02_00_00_02_07, 64'h5F40_02_01_00_02_FF_10,
    64'h5B40_0D_19_01_0D_0C_01, 64'h5940_1A_1B_00_00_1B_07, 64'h5B40_0E_03_01_0E_F5_10,
    64'h5D40_01_80_00_7F_80_09, 64'h6940_33_5A_15_33_FF_15};
  // Fill opcode, control value, memory address it must reach
  localparam logic [31:0] ADR [5] = '{
    32'h6830_0030, 32'h6880_0F80, 32'h6810_1310, 32'h6860_1F60, 32'h695F_135F};

  // Small memory would alias the banks, so the full space is kept
  sub_fill_sleep_exec #(.MEM_WORDS(4096), .PRESCALE(4), .POSTSCALE(4)) dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .core_asleep);

  // ****
  // Bus tasks
  // ****
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_val({30'h0, got}, {30'h0, exp});
  endtask
  // Ready is held low a cycle so the response must stand while it waits
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= x;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b0;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    chk_resp(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b0;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    chk_resp(rresp, er);
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] x);
    wr(a, x, sub_exec_pkg::RESP_OKAY);
  endtask
  task automatic get(input logic [7:0] a);
    rd(a, sub_exec_pkg::RESP_OKAY);
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****
  // Clock, watchdog and tests
  // ****
  initial begin
    forever #5 aclk = ~aclk;
  end
  // Whole run is about 600 cycles; eight times that is a hang
  initial begin
    #50us;
    bad_count++;
    close_out();
  end
  // Inputs start idle with reset asserted
  initial begin
    aresetn <= 1'b0;
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    arvalid <= 1'b0;
    bready  <= 1'b0;
    rready  <= 1'b0;
    awaddr  <= 8'h00;
    araddr  <= 8'h00;
    wdata   <= 32'h0;
    wstrb   <= 4'h3;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    get(sub_exec_pkg::OFS_STATUS);
    chk_val(d, 32'h060);
    rd(8'h20, sub_exec_pkg::RESP_SLVERR);
    chk_val(d, 32'h0);
    wr(8'h20, 32'hFF, sub_exec_pkg::RESP_SLVERR);
    $display("Test reset and map done");
    put(sub_exec_pkg::OFS_BANK, 32'h2);
    put(sub_exec_pkg::OFS_MEM_ADDR, 32'h240);
    foreach (VEC[i]) begin
      v = VEC[i];
      put(sub_exec_pkg::OFS_MEM_DATA, {24'h0, v[39:32]});
      put(sub_exec_pkg::OFS_ACC, {24'h0, v[47:40]});
      put(sub_exec_pkg::OFS_STATUS, {24'h0, v[31:24]});
      put(sub_exec_pkg::OFS_OPCODE, {16'h0, v[63:48]});
      get(sub_exec_pkg::OFS_ACC);
      chk_val(d, {24'h0, v[23:16]});
      get(sub_exec_pkg::OFS_MEM_DATA);
      chk_val(d, {24'h0, v[15:8]});
      get(sub_exec_pkg::OFS_STATUS);
      chk_val(d & 32'h1F, {24'h0, v[7:0]});
    end
    $display("Test arithmetic done");
    put(sub_exec_pkg::OFS_INDEX, 32'h300);
    put(sub_exec_pkg::OFS_BANK, 32'h3);
    foreach (ADR[i]) begin
      put(sub_exec_pkg::OFS_CTRL, {28'h0, ADR[i][15:12]});
      put(sub_exec_pkg::OFS_MEM_ADDR, {20'h0, ADR[i][11:0]});
      put(sub_exec_pkg::OFS_MEM_DATA, 32'h0);
      put(sub_exec_pkg::OFS_OPCODE, {16'h0, ADR[i][31:16]});
      get(sub_exec_pkg::OFS_MEM_DATA);
      chk_val(d, 32'hFF);
    end
    $display("Test addressing done");
    put(sub_exec_pkg::OFS_CTRL, 32'h0);
    put(sub_exec_pkg::OFS_OPCODE, {16'h0, sub_exec_pkg::OPC_SLEEP});
    get(sub_exec_pkg::OFS_STATUS);
    chk_val(d & 32'hE0, 32'hC0);
    chk_val({31'h0, core_asleep}, 32'h1);
    put(sub_exec_pkg::OFS_CTRL, 32'h4);
    get(sub_exec_pkg::OFS_STATUS);
    chk_val({31'h0, core_asleep}, 32'h0);
    // Watchdog on; sleep must restart its count before the wake
    put(sub_exec_pkg::OFS_CTRL, 32'h2);
    put(sub_exec_pkg::OFS_OPCODE, {16'h0, sub_exec_pkg::OPC_SLEEP});
    do @(posedge aclk); while (!core_asleep);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (core_asleep);
    chk_val({31'h0, n >= WD - 4}, 32'h1);
    get(sub_exec_pkg::OFS_STATUS);
    chk_val(d & 32'hE0, 32'h00);
    // Unknown opcode raises only its status bit; flags keep the last value
    put(sub_exec_pkg::OFS_OPCODE, 32'h0);
    get(sub_exec_pkg::OFS_STATUS);
    chk_val(d & 32'h11F, 32'h115);
    $display("Test sleep done");
    close_out();
  end
endmodule
`default_nettype wire
